// file: gcdr_top.sv
// gcdr_top: global configuration flags and routing of events to the two diagnostic outputs
// assumes classic wishbone master on core_clk; sequencer_bypass_pin is an asynchronous pin
//
// Behaviour
// - recalibrate zero crossing while driver is disabled
// - standstill timeout 2^18 or 2^20 clocks
// - enable voltage pwm; software switches at standstill
// - step filter enable, resets to one
// - invert motor direction
// - output a active on driver faults
// - output a active low during reset
// - output a active on heat warning
// - output a active on stall
// - no bypass: output a interrupt or step
// - output b active on stall
// - no bypass: output b compare or direction
// - output b active at table zero
// - output b active while chopper on
// - output b toggles per skipped step
// - configuration resets to 18'h00008, step filter only set
// - output a open drain low or push-pull high
`timescale 1ns/1ps
module gcdr_top #(
  parameter logic [20:0] SS_LONG_CNT = gcdr_pkg::GCDR_SS_LONG,
  parameter logic [20:0] SS_SHORT_CNT = gcdr_pkg::GCDR_SS_SHORT
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic sequencer_bypass_pin,
  input wire gcdr_pkg::gcdr_evt_s evt_i,
  output gcdr_pkg::gcdr_ctl_s ctl_o,
  output logic event_out_a_o,
  output logic event_out_a_oe,
  output logic event_out_b_o,
  output logic event_out_b_oe
);
  import gcdr_pkg::*;

  typedef struct packed {
    logic [GCDR_CFG_W-1:0] cfg;
    logic ack;
    logic err;
    logic [31:0] rdat;
    logic a_act;
    logic b_act;
    logic skip_tgl;
    logic step_tgl;
    logic in_reset;
    logic [20:0] ss_age;
  } gcdr_st_s;
  gcdr_st_s st_q, st_d;

  logic bypass;
  logic standstill;
  logic req;
  logic hit_cfg;
  logic hit_evt;
  logic hit_stat;
  logic [31:0] rd_mux;
  logic [20:0] ss_limit;

  //////////////////////////////////////////////////////////////////////////////
  gcdr_sync #(.W(1)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .async_in(sequencer_bypass_pin),
    .sync_out(bypass)
  );

  gcdr_standstill #(.LONG_CNT(SS_LONG_CNT), .SHORT_CNT(SS_SHORT_CNT)) u_ss (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .fast(st_q.cfg[GCDR_B_FASTSS]),
    .step_pulse(evt_i.step_pulse),
    .standstill(standstill)
  );

  //////////////////////////////////////////////////////////////////////////////
  assign req = wb_cyc_i && wb_stb_i && !st_q.ack && !st_q.err;
  // msb flags a write, decode ignores it
  assign hit_cfg = wb_adr_i[6:0] == GCDR_ADR_CFG[6:0];
  assign hit_evt = wb_adr_i[6:0] == GCDR_ADR_EVT[6:0];
  assign hit_stat = wb_adr_i[6:0] == GCDR_ADR_STAT[6:0];

  always_comb begin
    rd_mux = '0;
    if (hit_cfg) begin
      rd_mux = {14'h0000, st_q.cfg};
    end else if (hit_evt) begin
      rd_mux = {30'h00000000, st_q.b_act, st_q.a_act};
    end else if (hit_stat) begin
      rd_mux = {29'h00000000, st_q.skip_tgl, standstill, bypass};
    end
  end

  always_comb begin
    logic a_hit;
    logic b_hit;
    logic [GCDR_CFG_W-1:0] c;
    a_hit = 1'b0;
    b_hit = 1'b0;
    c = st_q.cfg;
    st_d = st_q;
    if (ce) begin
      st_d.in_reset = 1'b0;
      st_d.ack = req && (hit_cfg || hit_evt || hit_stat);
      st_d.err = req && !(hit_cfg || hit_evt || hit_stat);
      if (req) begin
        st_d.rdat = rd_mux;
      end
      if (req && wb_we_i && hit_cfg) begin
        if (wb_sel_i[0]) begin
          st_d.cfg[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          st_d.cfg[15:8] = wb_dat_i[15:8];
        end
        if (wb_sel_i[2]) begin
          st_d.cfg[17:16] = wb_dat_i[17:16];
        end
      end
      if (evt_i.step_skipped) begin
        st_d.skip_tgl = !st_q.skip_tgl;
      end
      if (evt_i.step_pulse) begin
        st_d.step_tgl = !st_q.step_tgl;
      end
      // age since last step, for the timeout check
      if (evt_i.step_pulse) begin
        st_d.ss_age = '0;
      end else if (st_q.ss_age != 21'h1fffff) begin
        st_d.ss_age = st_q.ss_age + 21'h000001;
      end
      if (bypass) begin
        a_hit = a_hit || (c[GCDR_B_A_FAULT] &&
          (evt_i.overheat_flag || evt_i.ground_short_flag || evt_i.pump_undervoltage_flag));
        a_hit = a_hit || (c[GCDR_B_A_HEAT] && evt_i.heat_warning);
        a_hit = a_hit || (c[GCDR_B_A_STALL] && evt_i.stall);
        b_hit = b_hit || (c[GCDR_B_B_STALL] && evt_i.stall);
        b_hit = b_hit || (c[GCDR_B_B_ZERO] && evt_i.table_zero);
        b_hit = b_hit || (c[GCDR_B_B_CHOP] && evt_i.chopper_on);
        b_hit = b_hit || (c[GCDR_B_B_SKIP] && st_d.skip_tgl);
      end else begin
        a_hit = c[GCDR_B_A_STALL] ? st_d.step_tgl : evt_i.interrupt;
        b_hit = c[GCDR_B_B_STALL] ? (evt_i.dir ^ c[GCDR_B_INV]) : evt_i.pos_compare;
      end
      st_d.a_act = a_hit;
      st_d.b_act = b_hit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.cfg <= GCDR_CFG_RST;
      st_q.in_reset <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign wb_ack_o = st_q.ack;
  assign wb_err_o = st_q.err;
  assign wb_dat_o = st_q.ack ? st_q.rdat : 32'h00000000;

  assign ctl_o.recalibrate = st_q.cfg[GCDR_B_RECAL] && (evt_i.driver_enable_n || evt_i.chopper_off_zero);
  assign ctl_o.standstill = standstill;
  assign ss_limit = st_q.cfg[GCDR_B_FASTSS] ? SS_SHORT_CNT : SS_LONG_CNT;
  assign ctl_o.pwm_mode = st_q.cfg[GCDR_B_PWM];
  assign ctl_o.step_filter = st_q.cfg[GCDR_B_FILT];
  assign ctl_o.dir_out = evt_i.dir ^ st_q.cfg[GCDR_B_INV];

  always_comb begin
    if (!rstn || st_q.in_reset) begin
      event_out_a_o = 1'b0;
      event_out_a_oe = 1'b1;
    end else if (st_q.cfg[GCDR_B_A_DRIVE]) begin
      event_out_a_o = st_q.a_act;
      event_out_a_oe = 1'b1;
    end else begin
      event_out_a_o = 1'b0;
      event_out_a_oe = st_q.a_act;
    end
  end
  assign event_out_b_o = st_q.b_act;
  assign event_out_b_oe = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  cfg_reset_a: assert property (@(posedge core_clk) !rstn |=> st_q.cfg == GCDR_CFG_RST)
    else $error("config not at reset value");
  out_a_reset_a: assert property (@(posedge core_clk) !rstn |-> event_out_a_oe && !event_out_a_o)
    else $error("output a not low in reset");
  fault_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_A_FAULT] && evt_i.overheat_flag |=> st_q.a_act)
    else $error("fault not routed to a");
  heat_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_A_HEAT] && evt_i.heat_warning |=> st_q.a_act)
    else $error("heat warning not routed");
  stall_b_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_B_STALL] && evt_i.stall |=> st_q.b_act)
    else $error("stall not routed to b");
  irq_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && !bypass && !st_q.cfg[GCDR_B_A_STALL] |=> st_q.a_act == $past(evt_i.interrupt))
    else $error("interrupt not routed");
  cmp_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && !bypass && !st_q.cfg[GCDR_B_B_STALL] |=> st_q.b_act == $past(evt_i.pos_compare))
    else $error("compare not routed");
  idle_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[11:5] == 7'h00 |=> !st_q.a_act && !st_q.b_act)
    else $error("output active with no source");
  opendrain_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !st_q.in_reset && !st_q.cfg[GCDR_B_A_DRIVE] |-> !event_out_a_o && event_out_a_oe == st_q.a_act)
    else $error("open drain form wrong");
  wb_ack_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && req |=> wb_ack_o || wb_err_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
  recal_a: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q.cfg[GCDR_B_RECAL] && evt_i.driver_enable_n |-> ctl_o.recalibrate)
    else $error("no recalibration when disabled");
  stall_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_A_STALL] && evt_i.stall |=> st_q.a_act)
    else $error("stall not routed to a");
  fault_any_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_A_FAULT] && (evt_i.ground_short_flag || evt_i.pump_undervoltage_flag)
    |=> st_q.a_act)
    else $error("short or pump fault not routed");
  zero_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_B_ZERO] && evt_i.table_zero |=> st_q.b_act)
    else $error("table zero not routed");
  chop_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_B_CHOP] && evt_i.chopper_on |=> st_q.b_act)
    else $error("chopper on not routed");
  skip_flip_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && evt_i.step_skipped |=> st_q.skip_tgl != $past(st_q.skip_tgl))
    else $error("skip toggle did not flip");
  skip_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bypass && st_q.cfg[GCDR_B_B_SKIP] && st_q.cfg[10:8] == 3'h0 |=> st_q.b_act == st_q.skip_tgl)
    else $error("skip toggle not routed");
  step_flip_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && !bypass && st_q.cfg[GCDR_B_A_STALL] && evt_i.step_pulse |=> st_q.a_act != $past(st_q.step_tgl))
    else $error("step output did not toggle");
  dir_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && !bypass && st_q.cfg[GCDR_B_B_STALL]
    |=> st_q.b_act == ($past(evt_i.dir) ^ $past(st_q.cfg[GCDR_B_INV])))
    else $error("direction not routed");
  pushpull_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !st_q.in_reset && st_q.cfg[GCDR_B_A_DRIVE] |-> event_out_a_oe && event_out_a_o == st_q.a_act)
    else $error("push-pull form wrong");
  cfg_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !(ce && req && wb_we_i && hit_cfg) |=> $stable(st_q.cfg))
    else $error("config changed without write");
  ss_reach_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && !evt_i.step_pulse && st_q.ss_age >= ss_limit - 21'h000001 |=> standstill)
    else $error("standstill not reached in time");
  ss_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && evt_i.step_pulse |=> !standstill)
    else $error("standstill kept after step");

  cfg_write_c: cover property (@(posedge core_clk) req && wb_we_i && hit_cfg);
  step_mode_c: cover property (@(posedge core_clk) !bypass && st_q.cfg[GCDR_B_A_STALL] && evt_i.step_pulse);
  skip_tgl_c: cover property (@(posedge core_clk) bypass && st_q.cfg[GCDR_B_B_SKIP] && evt_i.step_skipped);
  standstill_c: cover property (@(posedge core_clk) $rose(standstill));
  dir_mode_c: cover property (@(posedge core_clk) !bypass && st_q.cfg[GCDR_B_B_STALL] && evt_i.dir);
endmodule // gcdr_top

// file: gcdr_pkg.sv
// gcdr_pkg: register map, field positions and carriers for the global configuration block
// assumes a 32-bit classic wishbone slave port and a 100 MHz core clock
package gcdr_pkg;
  localparam int unsigned GCDR_CLK_MHZ = 100;
  localparam logic [7:0] GCDR_ADR_CFG = 8'h00;
  localparam logic [7:0] GCDR_ADR_EVT = 8'h04;
  localparam logic [7:0] GCDR_ADR_STAT = 8'h08;
  localparam int unsigned GCDR_CFG_W = 18;
  localparam int unsigned GCDR_B_RECAL = 0;
  localparam int unsigned GCDR_B_FASTSS = 1;
  localparam int unsigned GCDR_B_PWM = 2;
  localparam int unsigned GCDR_B_FILT = 3;
  localparam int unsigned GCDR_B_INV = 4;
  localparam int unsigned GCDR_B_A_FAULT = 5;
  localparam int unsigned GCDR_B_A_HEAT = 6;
  localparam int unsigned GCDR_B_A_STALL = 7;
  localparam int unsigned GCDR_B_B_STALL = 8;
  localparam int unsigned GCDR_B_B_ZERO = 9;
  localparam int unsigned GCDR_B_B_CHOP = 10;
  localparam int unsigned GCDR_B_B_SKIP = 11;
  localparam int unsigned GCDR_B_A_DRIVE = 12;
  localparam logic [17:0] GCDR_CFG_RST = 18'h00008;
  localparam int unsigned GCDR_SS_LONG_LOG2 = 20;
  localparam int unsigned GCDR_SS_SHORT_LOG2 = 18;
  localparam logic [20:0] GCDR_SS_LONG = 21'h100000;
  localparam logic [20:0] GCDR_SS_SHORT = 21'h040000;
  localparam int unsigned GCDR_SYNC_W = 12;

  // raw event inputs from the driver core, all same-clock except the pin
  typedef struct packed {
    logic overheat_flag;
    logic ground_short_flag;
    logic pump_undervoltage_flag;
    logic heat_warning;
    logic stall;
    logic table_zero;
    logic chopper_on;
    logic step_skipped;
    logic interrupt;
    logic pos_compare;
    logic step_pulse;
    logic dir;
    logic driver_enable_n;
    logic chopper_off_zero;
  } gcdr_evt_s;

  // configuration decoded for the driver core
  typedef struct packed {
    logic recalibrate;
    logic standstill;
    logic pwm_mode;
    logic step_filter;
    logic dir_out;
  } gcdr_ctl_s;
endpackage

// file: gcdr_sync.sv
// gcdr_sync: two-flop synchroniser for a vector of pin levels
// assumes inputs arrive asynchronous to core_clk
`timescale 1ns/1ps
module gcdr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } gcdr_sync_s;
  gcdr_sync_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.meta = async_in;
      st_d.sync = st_q.meta;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync;
endmodule // gcdr_sync

// file: gcdr_standstill.sv
// gcdr_standstill: counts clocks since the last executed step
// assumes step_pulse is one cycle per executed step, same clock
`timescale 1ns/1ps
module gcdr_standstill #(
  parameter logic [20:0] LONG_CNT = gcdr_pkg::GCDR_SS_LONG,
  parameter logic [20:0] SHORT_CNT = gcdr_pkg::GCDR_SS_SHORT
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic fast,
  input wire logic step_pulse,
  output logic standstill
);
  import gcdr_pkg::*;
  typedef struct packed {
    logic [20:0] cnt;
    logic still;
  } gcdr_ss_s;
  gcdr_ss_s st_q, st_d;
  logic [20:0] limit;

  assign limit = fast ? SHORT_CNT : LONG_CNT;

  always_comb begin
    st_d = st_q;
    if (ce) begin
      if (step_pulse) begin
        st_d.cnt = '0;
        st_d.still = 1'b0;
      end else if (st_q.cnt >= limit - 21'h000001) begin
        st_d.still = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 21'h000001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign standstill = st_q.still;
endmodule // gcdr_standstill

// file: gcdr_pins.sv
// gcdr_pins: board side of the two diagnostic outputs, pull-ups on both lines
// assumes oe is high while the block drives a line
`timescale 1ns/1ps
module gcdr_pins (
  input wire logic a_o,
  input wire logic a_oe,
  input wire logic b_o,
  input wire logic b_oe,
  output logic pin_a,
  output logic pin_b
);
  // released lines float to the pull-up level
  assign pin_a = a_oe ? a_o : 1'b1;
  assign pin_b = b_oe ? b_o : 1'b1;
endmodule // gcdr_pins

// file: test_global_config_diag_routing.sv
// test_global_config_diag_routing: self-checking bench for configuration flags and event routing
// assumes gcdr_top on one 100 MHz clock and gcdr_pins resolving the output lines
`timescale 1ns/1ps
module test_global_config_diag_routing;
  import gcdr_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic byp = 1'b0;
  gcdr_evt_s evt = '0;
  gcdr_ctl_s ctl;
  logic [31:0] dat_o, q, c, r;
  logic ack, err, e, a_o, a_oe, b_o, b_oe, pin_a, pin_b;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'd56;
  int ea, eb;

  localparam int SS_LONG = 64;
  localparam int SS_SHORT = 16;

  always #5 core_clk = ~core_clk;

  gcdr_top #(.SS_LONG_CNT(21'(SS_LONG)), .SS_SHORT_CNT(21'(SS_SHORT))) gcdr_top_i (.core_clk(core_clk),
    .rstn(rstn), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .sequencer_bypass_pin(byp), .evt_i(evt), .ctl_o(ctl), .event_out_a_o(a_o),
    .event_out_a_oe(a_oe), .event_out_b_o(b_o), .event_out_b_oe(b_oe));
  gcdr_pins gcdr_pins_i (.a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .pin_a(pin_a), .pin_b(pin_b));

  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one classic cycle, held until ack or err is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= w ? (a | 8'h80) : a;
    sel <= 4'hf;
    wdat <= d;
    while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    q = dat_o;
    e = err;
    chk(32'(n < 20), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task do_reset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({29'h0, a_oe, a_o, pin_a}, 32'h4);
    rstn <= 1'b1;
    wb(1'b0, GCDR_ADR_CFG, 32'h0);
    chk(q, 32'h00000008);
  endtask

  task set_byp(input logic m);
    @(posedge core_clk);
    byp <= m;
    repeat (4) @(posedge core_clk);
  endtask

  task pulse(input int k);
    @(posedge core_clk);
    if (k == 0) evt.step_pulse <= 1'b1;
    else evt.step_skipped <= 1'b1;
    @(posedge core_clk);
    evt.step_pulse <= 1'b0;
    evt.step_skipped <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      c = xs() & 32'h0003ffff;
      wb(1'b1, GCDR_ADR_CFG, c);
      wb(1'b0, GCDR_ADR_CFG, 32'h0);
      chk(q, c);
    end
    wb(1'b1, 8'h0c, 32'hffffffff);
    chk(32'(e), 32'h1);
    wb(1'b0, GCDR_ADR_CFG, 32'h0);
    chk(q, c);
    $display("test register access done");
    for (int i = 0; i < 48; i++) begin
      if (i % 8 == 0) set_byp((i / 8) % 2 == 0);
      c = xs() & 32'h000017ff;
      if (byp) c[11] = 1'b0;
      else c[7] = 1'b0;
      wb(1'b1, GCDR_ADR_CFG, c);
      r = xs();
      evt <= gcdr_evt_s'(r[13:0] & 14'h3fb7);
      wb(1'b0, GCDR_ADR_EVT, 32'h0);
      ea = byp ? (c[5] & (evt.overheat_flag | evt.ground_short_flag | evt.pump_undervoltage_flag))
        | (c[6] & evt.heat_warning) | (c[7] & evt.stall) : evt.interrupt;
      eb = byp ? (c[8] & evt.stall) | (c[9] & evt.table_zero) | (c[10] & evt.chopper_on)
        : (c[8] ? evt.dir ^ c[4] : evt.pos_compare);
      chk(q, 32'(eb * 2 + ea));
      chk(32'(pin_a), 32'(c[12] ? ea : 1 - ea));
      chk(32'(pin_b), 32'(eb));
      chk(32'({ctl.recalibrate, ctl.pwm_mode, ctl.step_filter, ctl.dir_out}),
        32'({c[0] & (evt.driver_enable_n | evt.chopper_off_zero), c[2], c[3], evt.dir ^ c[4]}));
    end
    $display("test routing done");
    for (int k = 0; k < 2; k++) begin
      set_byp(k == 1);
      evt <= '0;
      wb(1'b1, GCDR_ADR_CFG, (k == 1) ? 32'h800 : 32'h80);
      wb(1'b0, GCDR_ADR_EVT, 32'h0);
      ea = q[k];
      pulse(k);
      wb(1'b0, GCDR_ADR_EVT, 32'h0);
      chk(32'(q[k]), 32'(1 - ea));
      pulse(k);
      pulse(k);
      wb(1'b0, GCDR_ADR_EVT, 32'h0);
      chk(32'(q[k]), 32'(1 - ea));
    end
    $display("test toggles done");
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, GCDR_ADR_CFG, 32'(k * 2));
      pulse(0);
      repeat ((k == 1) ? SS_SHORT : SS_LONG) @(posedge core_clk);
      chk(32'(ctl.standstill), 32'h0);
      @(posedge core_clk);
      chk(32'(ctl.standstill), 32'h1);
      wb(1'b0, GCDR_ADR_STAT, 32'h0);
      chk(32'(q[1]), 32'h1);
    end
    $display("test standstill done");
    do_reset();
    $display("test second reset done");
    results();
  end

  initial begin
    #500000;
    err_count++;
    results();
  end
endmodule // test_global_config_diag_routing
